/* File: hdl/asi_pkg.sv */
/*
 Shared constants for the access sequence status indicator: register map,
 sequence state codes, blink and timeout figures.
 Assumes a 125 MHz system clock.
*/
package asi_pkg;
	localparam int unsigned CLK_HZ        = 125_000_000;
	localparam int unsigned SLOW_BLINK_HZ = 1;
	localparam int unsigned FAST_BLINK_HZ = 4;
	localparam int unsigned PAUSE_S       = 2;
	localparam int unsigned EXIT_LIMIT_S  = 60;
	localparam int unsigned CHECK_MIN_MS  = 500;
	localparam int unsigned CHECK_MAX_MS  = 10_000;
	// Half periods of the blink rates, in cycles
	localparam int unsigned SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_BLINK_HZ);
	localparam int unsigned FAST_HALF_CYC = CLK_HZ / (2 * FAST_BLINK_HZ);
	localparam int unsigned PAUSE_CYC     = CLK_HZ * PAUSE_S;
	// Exit limit needs more than 32 bits at the full clock rate
	localparam longint unsigned EXIT_CYC  = 64'(CLK_HZ) * EXIT_LIMIT_S;
	localparam int unsigned CHECK_MIN_CYC = (CLK_HZ / 1000) * CHECK_MIN_MS;
	localparam int unsigned CHECK_MAX_CYC = (CLK_HZ / 1000) * CHECK_MAX_MS;

	// Register byte offsets
	localparam logic [3:0] CTRL_OFS   = 4'h0;
	localparam logic [3:0] STATUS_OFS = 4'h4;
	// Control fields
	localparam int unsigned CTRL_CLR_BIT = 0;
	localparam int unsigned CTRL_DIS_BIT = 1;
	localparam logic [1:0]  CTRL_RST_VAL = 2'h0;
	// Status fields
	localparam int unsigned ST_SEQERR_BIT = 0;
	localparam int unsigned ST_HWERR_BIT  = 1;
	localparam int unsigned ST_STATE_LSB  = 4;

	// Indicator patterns
	typedef enum logic [2:0] {
		PAT_OFF    = 3'b000,
		PAT_ON     = 3'b001,
		PAT_SLOW   = 3'b010,
		PAT_FAST   = 3'b011,
		PAT_DBL    = 3'b100,
		PAT_QUAD   = 3'b101
	} asi_pat_t;

	// Sequence states
	typedef enum logic [3:0] {
		ST_RUN       = 4'b0000,
		ST_STOPPING  = 4'b0001,
		ST_OPEN_WAIT = 4'b0010,
		ST_INSIDE    = 4'b0011,
		ST_CHECKING  = 4'b0100,
		ST_EXITING   = 4'b0101,
		ST_CLOSED    = 4'b0110,
		ST_LOCK_WAIT = 4'b0111,
		ST_RESET_REQ = 4'b1000,
		ST_LOCK_FAIL = 4'b1001,
		ST_SEQ_ERR   = 4'b1010,
		ST_HW_ERR    = 4'b1011,
		ST_KEY_AWAY  = 4'b1100
	} asi_state_t;
endpackage

/* File: hdl/asi_blink.sv */
/*
 Pattern generator for one indicator: steady, 1 Hz, 4 Hz, and flash bursts
 followed by a two second dark pause.
 Assumes restart pulses whenever the selected pattern changes.
*/
`timescale 1ns/1ns
module asi_blink
	import asi_pkg::*;
#(
	parameter int unsigned SLOW_HALF = SLOW_HALF_CYC,
	parameter int unsigned FAST_HALF = FAST_HALF_CYC,
	parameter int unsigned PAUSE     = PAUSE_CYC
) (
	// Clock and reset
	input  wire logic     aclk,
	input  wire logic     aresetn,
	// Pattern control
	input  wire asi_pat_t pattern,
	input  wire logic     restart,
	// Lamp drive
	output logic          lamp
);
	localparam int CW = $clog2(PAUSE + 1);

	logic [CW-1:0] cnt_q;
	logic          phase_q;
	logic [2:0]    flashes_q;
	logic          paused_q;
	logic [CW-1:0] half;
	logic [2:0]    burst;

	// Burst patterns pick the rate and the flash count
	always_comb begin
		half  = (pattern == PAT_FAST || pattern == PAT_QUAD) ? CW'(FAST_HALF) : CW'(SLOW_HALF);
		burst = (pattern == PAT_QUAD) ? 3'h4 : 3'h2;
	end

	// Timebase, restarted so a new blinking pattern always begins lit
	always_ff @(posedge aclk) begin
		if (!aresetn || restart) begin
			cnt_q     <= '0;
			phase_q   <= 1'b1;
			flashes_q <= 3'h0;
			paused_q  <= 1'b0;
		end else if (paused_q) begin
			if (cnt_q == CW'(PAUSE - 1)) begin
				cnt_q    <= '0;
				paused_q <= 1'b0;
				phase_q  <= 1'b1;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end else if (cnt_q == half - 1'b1) begin
			cnt_q   <= '0;
			phase_q <= ~phase_q;
			// Count completed flashes at the end of each dark half
			if (!phase_q && (pattern == PAT_DBL || pattern == PAT_QUAD)) begin
				if (flashes_q == burst - 3'h1) begin
					flashes_q <= 3'h0;
					paused_q  <= 1'b1;
					phase_q   <= 1'b0;
				end else begin
					flashes_q <= flashes_q + 3'h1;
				end
			end
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// Lamp output from a flip-flop
	always_ff @(posedge aclk) begin
		if (!aresetn)
			lamp <= 1'b0;
		else case (pattern)
			PAT_OFF:  lamp <= 1'b0;
			PAT_ON:   lamp <= 1'b1;
			default:  lamp <= phase_q & ~paused_q;
		endcase
	end
endmodule

/* File: hdl/asi_top.sv */
/*
 Access sequence status indicator: tracks the key based entry and exit
 sequence of one guarded door and drives the entry and clearance lamps,
 relay channel lamps, the error flags and the latch lock request.
 Assumes synchronous, debounced inputs and an AXI4-Lite master.
*/
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module asi_top
	import asi_pkg::*;
#(
	parameter int unsigned SLOW_HALF = SLOW_HALF_CYC,
	parameter int unsigned FAST_HALF = FAST_HALF_CYC,
	parameter int unsigned PAUSE     = PAUSE_CYC,
	parameter longint unsigned EXIT_MAX = EXIT_CYC,
	parameter int unsigned CHK_MIN   = CHECK_MIN_CYC,
	parameter int unsigned CHK_MAX   = CHECK_MAX_CYC
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write channels
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read channels
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Operator side
	input  wire logic        entry_key_in,
	input  wire logic        clear_key_in,
	input  wire logic        door_closed,
	input  wire logic        latch_locked,
	input  wire logic        reset_button,
	// Machine side
	input  wire logic        relay_channel_one,
	input  wire logic        relay_channel_two,
	input  wire logic        standstill,
	input  wire logic        hw_fault_in,
	// Outputs
	output logic             relay_enable,
	output logic             latch_lock_req,
	output logic             entry_green,
	output logic             entry_blue,
	output logic             entry_white,
	output logic             clear_white,
	output logic             relay_one_lamp,
	output logic             relay_two_lamp,
	output logic             sequence_error_flag,
	output logic             hardware_fault_flag
);
	localparam int TW = $clog2((EXIT_MAX > CHK_MAX ? EXIT_MAX : CHK_MAX) + 1);

	asi_state_t    state_q, state_d;
	logic [TW-1:0] tmr_q;
	logic          seq_err_q, hw_err_q;
	logic [1:0]    ctrl_q;
	logic          relay_on;
	logic          state_chg;
	logic          key_hold_ok;
	logic          clear_key_q;
	asi_pat_t      pat_g, pat_b, pat_we, pat_wc;
	asi_pat_t      pat_g_q, pat_b_q, pat_we_q, pat_wc_q;

	assign relay_on  = relay_channel_one & relay_channel_two;
	assign state_chg = (state_d != state_q);

	// Key held in clearance holder within the allowed window
	assign key_hold_ok = (tmr_q >= TW'(CHK_MIN)) && (tmr_q <= TW'(CHK_MAX));

	// Sequence state machine
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_RUN:
				if (!entry_key_in || !door_closed)
					state_d = ST_STOPPING;
			ST_STOPPING:
				// Latch held until standstill confirmed
				if (standstill)
					state_d = ST_OPEN_WAIT;
			ST_OPEN_WAIT:
				if (!door_closed)
					state_d = ST_INSIDE;
				else if (entry_key_in)
					state_d = ST_KEY_AWAY;
			ST_KEY_AWAY:
				// Door never opened, so reinsertion needs only a reset
				state_d = ST_LOCK_WAIT;
			ST_INSIDE:
				if (clear_key_in)
					state_d = ST_CHECKING;
				else if (door_closed && entry_key_in)
					state_d = ST_SEQ_ERR;
			ST_CHECKING:
				if (!clear_key_in)
					state_d = key_hold_ok ? ST_EXITING : ST_INSIDE;
			ST_EXITING:
				if (tmr_q >= TW'(EXIT_MAX - 1))
					state_d = ST_SEQ_ERR;
				else if (door_closed)
					state_d = ST_CLOSED;
			ST_CLOSED:
				if (!door_closed)
					state_d = ST_INSIDE;
				else if (entry_key_in)
					state_d = ST_LOCK_WAIT;
			ST_LOCK_WAIT:
				if (latch_locked)
					state_d = ST_RESET_REQ;
				else if (tmr_q >= TW'(PAUSE - 1))
					state_d = ST_LOCK_FAIL;
			ST_LOCK_FAIL:
				if (latch_locked)
					state_d = ST_RESET_REQ;
			ST_RESET_REQ:
				if (!latch_locked || !door_closed)
					state_d = ST_LOCK_FAIL;
				else if (reset_button)
					state_d = ST_RUN;
			ST_SEQ_ERR:
				// Only the clearance key (a fresh checkout) or a hardware fault leaves it
				if (clear_key_in)
					state_d = ST_CHECKING;
			ST_HW_ERR:
				if (!hw_fault_in && ctrl_q[CTRL_CLR_BIT])
					state_d = ST_STOPPING;
			default:
				state_d = ST_STOPPING;
		endcase
		if (hw_fault_in && state_q != ST_HW_ERR)
			state_d = ST_HW_ERR;
		// Software freeze holds the safe stop path only
		if (ctrl_q[CTRL_DIS_BIT] && state_q == ST_RUN)
			state_d = ST_STOPPING;
	end

	// State register, safe stop after reset
	always_ff @(posedge aclk) begin
		if (!aresetn)
			state_q <= ST_STOPPING;
		else
			state_q <= state_d;
	end

	// Interval timer restarted on every state change
	always_ff @(posedge aclk) begin
		if (!aresetn || state_chg)
			tmr_q <= '0;
		else if (tmr_q != {TW{1'b1}})
			tmr_q <= tmr_q + 1'b1;
	end

	// Error flags; set wins over a software clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seq_err_q <= 1'b0;
			hw_err_q  <= 1'b0;
		end else begin
			seq_err_q <= (state_d == ST_SEQ_ERR) | (state_q == ST_LOCK_FAIL) |
				(seq_err_q & ~ctrl_q[CTRL_CLR_BIT]);
			hw_err_q  <= hw_fault_in | (hw_err_q & ~ctrl_q[CTRL_CLR_BIT]);
		end
	end
	assign sequence_error_flag = seq_err_q;
	assign hardware_fault_flag = hw_err_q;

	// Relay enable and latch lock request from flip-flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			relay_enable   <= 1'b0;
			latch_lock_req <= 1'b1;
		end else begin
			relay_enable   <= (state_d == ST_RUN);
			latch_lock_req <= !(state_d inside {ST_OPEN_WAIT, ST_INSIDE, ST_CHECKING,
				ST_EXITING, ST_SEQ_ERR});
		end
	end

	// Relay channel lamps mirror each channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			relay_one_lamp <= 1'b0;
			relay_two_lamp <= 1'b0;
		end else begin
			relay_one_lamp <= relay_channel_one;
			relay_two_lamp <= relay_channel_two;
		end
	end

	// Lamp pattern selection per state
	always_comb begin
		// Green follows relay and stop status
		if (relay_on)
			pat_g = PAT_ON;
		else if (!standstill)
			pat_g = PAT_SLOW;
		else
			pat_g = PAT_OFF;
		pat_b = (state_q == ST_RESET_REQ) ? PAT_SLOW : PAT_OFF;
		case (state_q)
			ST_RUN, ST_STOPPING: begin
				pat_we = PAT_OFF;
				pat_wc = PAT_OFF;
			end
			ST_OPEN_WAIT: begin
				pat_we = PAT_DBL;
				pat_wc = PAT_ON;
			end
			ST_KEY_AWAY: begin
				pat_we = PAT_DBL;
				pat_wc = PAT_ON;
			end
			ST_INSIDE: begin
				pat_we = PAT_ON;
				pat_wc = PAT_SLOW;
			end
			ST_CHECKING: begin
				pat_we = PAT_SLOW;
				pat_wc = PAT_ON;
			end
			ST_EXITING: begin
				pat_we = PAT_DBL;
				pat_wc = PAT_ON;
			end
			ST_CLOSED: begin
				pat_we = PAT_SLOW;
				pat_wc = PAT_ON;
			end
			ST_LOCK_FAIL: begin
				pat_we = PAT_QUAD;
				pat_wc = PAT_ON;
			end
			ST_SEQ_ERR, ST_HW_ERR: begin
				pat_we = PAT_FAST;
				pat_wc = PAT_FAST;
			end
			default: begin
				pat_we = PAT_OFF;
				pat_wc = PAT_OFF;
			end
		endcase
	end

	// Last patterns, so each lamp restarts cleanly on a change
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pat_g_q  <= PAT_OFF;
			pat_b_q  <= PAT_OFF;
			pat_we_q <= PAT_OFF;
			pat_wc_q <= PAT_OFF;
		end else begin
			pat_g_q  <= pat_g;
			pat_b_q  <= pat_b;
			pat_we_q <= pat_we;
			pat_wc_q <= pat_wc;
		end
	end

	asi_blink #(.SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF), .PAUSE(PAUSE)) u_green (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pattern (pat_g),
		.restart (pat_g != pat_g_q),
		.lamp    (entry_green)
	);
	asi_blink #(.SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF), .PAUSE(PAUSE)) u_blue (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pattern (pat_b),
		.restart (pat_b != pat_b_q),
		.lamp    (entry_blue)
	);
	asi_blink #(.SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF), .PAUSE(PAUSE)) u_went (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pattern (pat_we),
		.restart (pat_we != pat_we_q),
		.lamp    (entry_white)
	);
	asi_blink #(.SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF), .PAUSE(PAUSE)) u_wclr (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pattern (pat_wc),
		.restart (pat_wc != pat_wc_q),
		.lamp    (clear_white)
	);

	// AXI4-Lite write: take address and data in either order
	logic       aw_got_q, w_got_q;
	logic [3:0] aw_q;
	logic [1:0] wd_q;
	logic       w_strb0_q;

	assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
	assign s_axi_bresp   = 2'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q     <= 1'b0;
			w_got_q      <= 1'b0;
			aw_q         <= 4'h0;
			wd_q         <= 2'h0;
			w_strb0_q    <= 1'b0;
			s_axi_bvalid <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q <= 1'b1;
				aw_q     <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q   <= 1'b1;
				wd_q      <= s_axi_wdata[1:0];
				w_strb0_q <= s_axi_wstrb[0];
			end
			if (aw_got_q && w_got_q) begin
				aw_got_q     <= 1'b0;
				w_got_q      <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Control register; clear bit is self clearing
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ctrl_q <= CTRL_RST_VAL;
		else if (aw_got_q && w_got_q && aw_q == CTRL_OFS && w_strb0_q)
			ctrl_q <= wd_q;
		else
			ctrl_q[CTRL_CLR_BIT] <= 1'b0;
	end

	// AXI4-Lite read; unmapped offsets read zero with OKAY
	assign s_axi_arready = !s_axi_rvalid;
	assign s_axi_rresp   = 2'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			clear_key_q  <= 1'b0;
		end else begin
			clear_key_q <= clear_key_in;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				if (s_axi_araddr == CTRL_OFS)
					s_axi_rdata <= {30'h0, ctrl_q};
				else if (s_axi_araddr == STATUS_OFS)
					s_axi_rdata <= {24'h0, state_q, 2'h0, hw_err_q, seq_err_q};
				else
					s_axi_rdata <= 32'h0;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

/* File: dv/asi_top_assertions.sv */
/*
 Port checker for asi_top: lamp patterns, relay lamps, latch hold, hardware fault flag.
 Assumes the bind below and shortened blink half periods.
*/
`timescale 1ns/1ns
module asi_top_assertions #(
	parameter int unsigned SLOW_HALF = 4,
	parameter int unsigned FAST_HALF = 1
) (
	// Clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// Write response
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	// Machine and operator
	input wire logic       relay_channel_one,
	input wire logic       relay_channel_two,
	input wire logic       standstill,
	input wire logic       reset_button,
	input wire logic       hw_fault_in,
	// Block outputs
	input wire logic       relay_enable,
	input wire logic       latch_lock_req,
	input wire logic       entry_green,
	input wire logic       entry_blue,
	input wire logic       entry_white,
	input wire logic       clear_white,
	input wire logic       relay_one_lamp,
	input wire logic       relay_two_lamp,
	input wire logic       hardware_fault_flag
);
	logic       relay_on;
	logic       stopping;
	logic [7:0] g_hold_q;
	logic [7:0] w_hold_q;

	assign relay_on = relay_channel_one && relay_channel_two;
	assign stopping = !relay_on && !standstill;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Cycles a lamp stood still; a stuck blinker overruns the bound
	always_ff @(posedge aclk) begin
		g_hold_q <= (!aresetn || !stopping || entry_green != $past(entry_green)) ? 8'h00
			: g_hold_q + 8'h01;
		w_hold_q <= (!aresetn || !hardware_fault_flag || entry_white != $past(entry_white))
			? 8'h00 : w_hold_q + 8'h01;
	end

	sequence s_run_settled;
		relay_enable [*3];
	endsequence
	sequence s_safe_settled;
		(!relay_on && standstill) [*3];
	endsequence

	a_green_steady: assert property (relay_on [*3] |-> entry_green)
		else $error("green not steady with relay on");
	a_green_blinks: assert property (g_hold_q <= SLOW_HALF + 3)
		else $error("green not blinking while stopping");
	a_green_dark: assert property (s_safe_settled |-> !entry_green)
		else $error("green lit in safe state");
	a_white_idle: assert property (s_run_settled |-> !entry_white && !clear_white)
		else $error("white lit while running");
	a_blue_running: assert property (s_run_settled |-> !entry_blue)
		else $error("blue lit while running");
	a_run_after_press: assert property ($rose(relay_enable) |->
		$past(reset_button) || $past(reset_button, 2) || $past(reset_button, 3))
		else $error("relay enabled without reset press");
	a_latch_held: assert property (latch_lock_req && !standstill |=> latch_lock_req)
		else $error("latch released before standstill");
	a_hw_flag_set: assert property (hw_fault_in |-> ##[1:3] hardware_fault_flag)
		else $error("hardware fault flag not raised");
	a_hw_white_fast: assert property (w_hold_q <= FAST_HALF + 3)
		else $error("white not fast on hardware fault");
	a_relay_lamps: assert property ($past(aresetn) |-> relay_one_lamp == $past(relay_channel_one)
		&& relay_two_lamp == $past(relay_channel_two))
		else $error("relay lamp does not follow channel");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && s_axi_bresp == 2'h0)
		else $error("write response dropped early");
endmodule

bind asi_top asi_top_assertions #(.SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF))
	asi_top_assertions_i (.*);

/* File: dv/asi_far_model.sv */
/*
 Far side model: safety relay contacts, coasting machine, door lock.
 Assumes the block's relay and latch requests, plus the stall_stop and jam_lock scenario controls, as its stimulus.
*/
`timescale 1ns/1ns
module asi_far_model #(
	parameter int unsigned STOP_DLY = 6
) (
	// Clock
	input wire logic aclk,
	// Requests from the block
	input wire logic relay_enable,
	input wire logic latch_lock_req,
	// Scenario controls
	input wire logic stall_stop,
	input wire logic jam_lock,
	// Answers
	output logic     relay_channel_one,
	output logic     relay_channel_two,
	output logic     standstill,
	output logic     latch_locked
);
	int unsigned coast_q;

	initial begin
		relay_channel_one = 1'b0;
		relay_channel_two = 1'b0;
		standstill = 1'b0;
		latch_locked = 1'b0;
		coast_q = 0;
	end

	// Contacts follow the request a cycle late; the machine coasts before standstill
	always @(posedge aclk) begin
		relay_channel_one <= relay_enable;
		relay_channel_two <= relay_enable;
		latch_locked <= latch_lock_req && !jam_lock;
		coast_q <= relay_enable ? STOP_DLY : (coast_q != 0 ? coast_q - 1 : 0);
		standstill <= !relay_enable && coast_q == 0 && !stall_stop;
	end
endmodule

/* File: dv/tb_asi_top.sv */
/*
 Testbench for asi_top: entry, work, exit timeout and fault sequences.
 Assumes the far side model and the bound port checker.
*/
`timescale 1ns/1ns
module tb_asi_top;
	import asi_pkg::*;
	localparam int unsigned EXIT_MAX = 60;
	logic        aclk, aresetn;
	logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr, lamps;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        entry_key_in, clear_key_in, door_closed, latch_locked, reset_button;
	logic        relay_channel_one, relay_channel_two, standstill, hw_fault_in;
	logic        relay_enable, latch_lock_req, entry_green, entry_blue, entry_white;
	logic        clear_white, relay_one_lamp, relay_two_lamp, stall_stop, jam_lock;
	logic        sequence_error_flag, hardware_fault_flag;
	int          err_total, n_compared, cyc;

	assign lamps = {clear_white, entry_white, entry_blue, entry_green};

	asi_top #(.SLOW_HALF(4), .FAST_HALF(1), .PAUSE(16), .EXIT_MAX(EXIT_MAX),
		.CHK_MIN(5), .CHK_MAX(100)) asi_top_i (.*);
	asi_far_model asi_far_model_i (.*);

	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	task automatic wait_n(input int n);
		repeat (n) @(posedge aclk);
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Counts rising edges and lit cycles of one lamp over a window
	task automatic blink(input string nm, input int i, input int n, input int rlo, input int rhi,
		input int hlo, input int hhi);
		int r, h;
		logic p;
		r = 0;
		h = 0;
		p = lamps[i];
		repeat (n) begin
			@(posedge aclk);
			r += int'(lamps[i] === 1'b1 && p === 1'b0);
			h += int'(lamps[i] === 1'b1);
			p = lamps[i];
		end
		n_compared++;
		if (r < rlo || r > rhi || h < hlo || h > hhi) begin
			err_total++;
			$display("Error %s expected rises %0d-%0d lit %0d-%0d seen %0d %0d",
				nm, rlo, rhi, hlo, hhi, r, h);
		end
	endtask

	// Address and data offered together, each released when taken
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_awvalid || s_axi_wvalid);
		while (s_axi_bvalid !== 1'b1) @(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!(s_axi_rvalid === 1'b1 && s_axi_rready));
		d = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic test_done();
		if (err_total == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// A hang counts as a mismatch
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			test_done();
		end
	end

	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
		s_axi_wstrb = 4'hf;
		{entry_key_in, door_closed} = 2'h3;
		{clear_key_in, reset_button, hw_fault_in, stall_stop, jam_lock} = 5'h00;
		wait_n(10);
		aresetn <= 1'b1;
		axi_rd(CTRL_OFS, rd);
		chk("ctrl reset", {30'h0, CTRL_RST_VAL}, rd);
		axi_rd(STATUS_OFS, rd);
		chk("status flags", 32'h0, {30'h0, rd[1:0]});
		axi_rd(4'h8, rd);
		chk("unmapped rresp", 32'h0, {30'h0, rr});
		// Locked and stopped with the key home: restart needs a press
		wait_n(20);
		blink("blue reset request", 1, 32, 3, 5, 12, 20);
		reset_button <= 1'b1;
		wait_n(2);
		reset_button <= 1'b0;
		wait_n(12);
		chk("relay enable", 32'h1, {31'h0, relay_enable});
		blink("green running", 0, 16, 0, 0, 16, 16);
		blink("white idle", 2, 16, 0, 0, 0, 0);
		chk("relay lamps", 32'h3, {30'h0, relay_one_lamp, relay_two_lamp});
		// Key out while the machine coasts on
		stall_stop <= 1'b1;
		entry_key_in <= 1'b0;
		wait_n(10);
		blink("green stopping", 0, 32, 3, 5, 12, 20);
		chk("latch held", 32'h1, {31'h0, latch_lock_req});
		stall_stop <= 1'b0;
		wait_n(20);
		blink("green safe", 0, 16, 0, 0, 0, 0);
		chk("latch released", 32'h0, {31'h0, latch_lock_req});
		blink("white door wait", 2, 64, 3, 5, 12, 20);
		// Operator inside with the door open
		door_closed <= 1'b0;
		wait_n(8);
		blink("white inside", 2, 16, 0, 0, 16, 16);
		blink("clear white checkout", 3, 32, 3, 5, 12, 20);
		// Checkout, then stay inside beyond the exit limit
		clear_key_in <= 1'b1;
		wait_n(20);
		clear_key_in <= 1'b0;
		wait_n(EXIT_MAX + 20);
		chk("seq flag", 32'h1, {31'h0, sequence_error_flag});
		chk("hw flag", 32'h0, {31'h0, hardware_fault_flag});
		blink("entry white error", 2, 32, 14, 17, 14, 18);
		blink("clear white error", 3, 32, 14, 17, 14, 18);
		axi_rd(STATUS_OFS, rd);
		chk("status flags", 32'h1, {30'h0, rd[1:0]});
		// Clear cannot drop the flag while the error state still stands
		axi_wr(CTRL_OFS, 32'h1);
		wait_n(3);
		chk("seq flag held", 32'h1, {31'h0, sequence_error_flag});
		// Hardware fault is flagged apart from sequence errors
		hw_fault_in <= 1'b1;
		wait_n(4);
		chk("hw flag", 32'h1, {31'h0, hardware_fault_flag});
		hw_fault_in <= 1'b0;
		axi_rd(STATUS_OFS, rd);
		chk("status flags", 32'h3, {30'h0, rd[1:0]});
		axi_wr(CTRL_OFS, 32'h1);
		wait_n(3);
		chk("hw flag cleared", 32'h0, {31'h0, hardware_fault_flag});
		chk("seq flag cleared", 32'h0, {31'h0, sequence_error_flag});
		// Too short a checkout sends the operator back inside
		wait_n(8);
		clear_key_in <= 1'b1;
		wait_n(2);
		clear_key_in <= 1'b0;
		wait_n(8);
		blink("clear white retry", 3, 32, 3, 5, 12, 20);
		// Full exit with a jammed lock, then a press to restart
		jam_lock <= 1'b1;
		clear_key_in <= 1'b1;
		wait_n(20);
		clear_key_in <= 1'b0;
		wait_n(4);
		door_closed <= 1'b1;
		wait_n(6);
		blink("entry white key wait", 2, 32, 3, 5, 12, 20);
		entry_key_in <= 1'b1;
		wait_n(24);
		blink("entry white lock fail", 2, 48, 7, 9, 6, 10);
		blink("clear white lock fail", 3, 16, 0, 0, 16, 16);
		chk("lock fail flag", 32'h1, {31'h0, sequence_error_flag});
		jam_lock <= 1'b0;
		wait_n(8);
		blink("blue after lock", 1, 32, 3, 5, 12, 20);
		reset_button <= 1'b1;
		wait_n(2);
		reset_button <= 1'b0;
		wait_n(4);
		chk("relay after exit", 32'h1, {31'h0, relay_enable});
		// Software force stop drops the relay request
		axi_wr(CTRL_OFS, 32'h2);
		wait_n(2);
		chk("force stop", 32'h0, {31'h0, relay_enable});
		test_done();
	end
endmodule
